// *** hdl/gpib_dev_defs.svh ***
`ifndef GPIB_DEV_DEFS_SVH
`define GPIB_DEV_DEFS_SVH

// Primary address default
`define GPIB_ADDR_DEFAULT  5'h10
// Command byte codes, low seven bits
`define GPIB_CMD_GTL       7'h01
`define GPIB_CMD_SDC       7'h04
`define GPIB_CMD_GET       7'h08
`define GPIB_CMD_DCL       7'h14
`define GPIB_CMD_SPE       7'h18
`define GPIB_CMD_SPD       7'h19
`define GPIB_CMD_UNL       7'h3f
`define GPIB_CMD_UNT       7'h5f
// Address group field
`define GPIB_GRP_LAG       2'h1
`define GPIB_GRP_TAG       2'h2
`define GPIB_GRP_SCG       2'h3
// Status byte request-service bit
`define GPIB_RQS_BIT       6

`endif

// *** hdl/gpib_dev_pkg.sv ***
package gpib_dev_pkg;

    // Bus control lines as seen at the pins, active high
    typedef struct packed {
        logic atn;
        logic ifc;
        logic ren;
        logic eoi;
    } bus_ctl_s;

    // Received byte towards the device function
    typedef struct packed {
        logic [7:0] data;
        logic       eoi;
    } rx_byte_s;

    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_WAIT = 2'b01,
        SH_DRIVE = 2'b10,
        SH_HOLD = 2'b11
    } sh_state_e;

    typedef enum logic [1:0] {
        AH_READY = 2'b00,
        AH_TAKE = 2'b01,
        AH_DONE = 2'b10
    } ah_state_e;

endpackage

// *** hdl/gpib_dev.sv ***
// How it works
// R1: Addressed commands need prior own listen address
// R2: Controller sends unlisten before addressing devices
// R3: Selective clear acts only when listen-addressed
// R4: Bytes with attention false are device data
// R5: Source handshake drives bytes when talking
// R6: Acceptor handshake latches every byte reliably; the code latches a byte only under attention or while listen-addressed
// R7: Data driven only after own talk address or in talk-only mode
// R8: Talker leaves on own listen; serial poll
// R9: Data accepted only while addressed listener
// R10: Listener leaves on own talk address
// R11: Service request and status byte on poll
// R12: Remote/local follows enable line and local
// R13: Universal or addressed clear resets device
// R14: Addressed trigger starts a reading
// R15: No parallel poll response ever
// R16: Never drives attention or interface clear
// R17: Primary addresses only, secondaries ignored
// R18: Serial poll enable/disable; status when talking
// R19: Three-wire handshake ordering on every byte
// R20: Interface clear drops all addressing at once
`include "gpib_dev_defs.svh"

module gpib_dev
    import gpib_dev_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic [4:0] my_addr_i,
    input  wire logic       talk_only_i,
    input  wire logic [7:0] dio_i,
    input  wire bus_ctl_s   ctl_i,
    input  wire logic       dav_i,
    input  wire logic       nrfd_i,
    input  wire logic       ndac_i,
    output logic [7:0]      dio_o,
    output logic [7:0]      dio_oe_o,
    output logic            dav_o,
    output logic            dav_oe_o,
    output logic            nrfd_o,
    output logic            nrfd_oe_o,
    output logic            ndac_o,
    output logic            ndac_oe_o,
    output logic            eoi_o,
    output logic            eoi_oe_o,
    output logic            srq_o,
    output logic            srq_oe_o,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_eoi_i,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o,
    output rx_byte_s        rx_o,
    output logic            rx_valid_o,
    input  wire logic       rx_ready_i,
    input  wire logic [7:0] status_i,
    input  wire logic       svc_req_i,
    output logic            listen_o,
    output logic            talk_o,
    output logic            remote_o,
    output logic            spoll_o,
    output logic            dev_clear_o,
    output logic            trigger_o
);

////////////////////////////////////////////////////////////////////////
    logic rst_s1_r;
    logic rst_b_r;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1_r <= 1'b0;
            rst_b_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_b_r  <= rst_s1_r;
        end
    end

////////////////////////////////////////////////////////////////////////
    // Acceptor handshake
    ah_state_e ah_r;
    logic [7:0] rx_byte_r;
    logic       rx_eoi_r;
    logic       rx_atn_r;
    logic       acc_pulse_r;
    logic       lacs_r;
    logic       tacs_r;
    logic       spe_r;
    logic       rem_r;
    logic       rx_valid_r;
    logic       rx_hold;
    logic       ah_on;

    // Holding back not-ready applies flow control to device data
    assign rx_hold = rx_valid_r && !rx_ready_i;
    // Idle acceptor frees both lines, else it would stall a talker
    assign ah_on   = ctl_i.atn || lacs_r || ah_r != AH_READY;

    always_ff @(posedge sys_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            ah_r        <= AH_READY;
            rx_byte_r   <= 8'h00;
            rx_eoi_r    <= 1'b0;
            rx_atn_r    <= 1'b0;
            acc_pulse_r <= 1'b0;
        end else begin
            acc_pulse_r <= 1'b0;
            if (ctl_i.ifc) begin
                ah_r <= AH_READY;                                  // R20
            end else begin
                case (ah_r)
                    AH_READY: begin
                        if (dav_i &&
                            (ctl_i.atn || (lacs_r && !rx_hold))) begin
                            rx_byte_r   <= dio_i;                  // R6
                            rx_eoi_r    <= ctl_i.eoi;
                            rx_atn_r    <= ctl_i.atn;
                            acc_pulse_r <= 1'b1;
                            ah_r        <= AH_TAKE;
                        end
                    end
                    AH_TAKE:  ah_r <= AH_DONE;
                    AH_DONE: begin
                        if (!dav_i) begin
                            ah_r <= AH_READY;                      // R19
                        end
                    end
                    default:  ah_r <= AH_READY;
                endcase
            end
        end
    end

////////////////////////////////////////////////////////////////////////
    // Command decode; secondaries fall in the ignored group
    logic [6:0] cmd;
    logic [1:0] grp;
    logic       is_cmd;
    logic       my_lag;
    logic       my_tag;

    assign cmd    = rx_byte_r[6:0];
    assign grp    = rx_byte_r[6:5];
    assign is_cmd = acc_pulse_r && rx_atn_r;
    assign my_lag = is_cmd && grp == `GPIB_GRP_LAG &&
                    rx_byte_r[4:0] == my_addr_i && cmd != `GPIB_CMD_UNL;
    assign my_tag = is_cmd && grp == `GPIB_GRP_TAG &&
                    rx_byte_r[4:0] == my_addr_i && cmd != `GPIB_CMD_UNT;

    always_ff @(posedge sys_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            lacs_r <= 1'b0;
            tacs_r <= 1'b0;
        end else if (ctl_i.ifc) begin
            lacs_r <= 1'b0;                                        // R20
            tacs_r <= 1'b0;
        end else if (talk_only_i) begin
            lacs_r <= 1'b0;                                        // R8
            tacs_r <= 1'b1;
        end else if (is_cmd) begin
            if (cmd == `GPIB_CMD_UNL) begin
                lacs_r <= 1'b0;                                    // R2
            end else if (my_lag) begin
                lacs_r <= 1'b1;                                    // R1
                tacs_r <= 1'b0;                                    // R8
            end else if (cmd == `GPIB_CMD_UNT) begin
                tacs_r <= 1'b0;
            end else if (my_tag) begin
                tacs_r <= 1'b1;                                    // R7
                lacs_r <= 1'b0;                                    // R10
            end else if (grp == `GPIB_GRP_TAG) begin
                tacs_r <= 1'b0;
            end
        end
    end                                                            // R17

////////////////////////////////////////////////////////////////////////
    // Addressed and universal commands
    always_ff @(posedge sys_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            spe_r       <= 1'b0;
            rem_r       <= 1'b0;
            dev_clear_o <= 1'b0;
            trigger_o   <= 1'b0;
        end else begin
            dev_clear_o <= 1'b0;
            trigger_o   <= 1'b0;
            if (!ctl_i.ren) begin
                rem_r <= 1'b0;                                     // R12
            end else if (my_lag) begin
                rem_r <= 1'b1;
            end else if (is_cmd && lacs_r && cmd == `GPIB_CMD_GTL) begin
                rem_r <= 1'b0;                                     // R12
            end
            if (ctl_i.ifc) begin
                spe_r <= 1'b0;
            end else if (is_cmd && cmd == `GPIB_CMD_SPE) begin
                spe_r <= 1'b1;                                     // R18
            end else if (is_cmd && cmd == `GPIB_CMD_SPD) begin
                spe_r <= 1'b0;                                     // R18
            end
            if (is_cmd && (cmd == `GPIB_CMD_DCL ||
                (lacs_r && cmd == `GPIB_CMD_SDC))) begin
                dev_clear_o <= 1'b1;                               // R3 R13
            end
            if (is_cmd && lacs_r && cmd == `GPIB_CMD_GET) begin
                trigger_o <= 1'b1;                                 // R14
            end
        end
    end

////////////////////////////////////////////////////////////////////////
    // Device data to the user side
    always_ff @(posedge sys_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            rx_valid_r <= 1'b0;
            rx_o       <= '0;
        end else if (acc_pulse_r && !rx_atn_r && lacs_r) begin
            rx_valid_r <= 1'b1;                                    // R4 R9
            rx_o       <= '{data: rx_byte_r, eoi: rx_eoi_r};
        end else if (rx_ready_i) begin
            rx_valid_r <= 1'b0;
        end
    end

////////////////////////////////////////////////////////////////////////
    // Source handshake
    sh_state_e  sh_r;
    logic [7:0] tx_byte_r;
    logic       tx_eoi_r;
    logic       tx_poll_r;
    logic       rsv_r;

    always_ff @(posedge sys_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            rsv_r <= 1'b0;
        end else if (svc_req_i) begin
            rsv_r <= 1'b1;                                         // R11
        end else if (sh_r == SH_HOLD && tx_poll_r && !ndac_i) begin
            rsv_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            sh_r      <= SH_IDLE;
            tx_byte_r <= 8'h00;
            tx_eoi_r  <= 1'b0;
            tx_poll_r <= 1'b0;
        end else if (ctl_i.ifc || ctl_i.atn || !tacs_r) begin
            sh_r <= SH_IDLE;                                       // R20
        end else begin
            case (sh_r)
                SH_IDLE: begin
                    if (spe_r) begin
                        tx_byte_r <= status_i;                     // R18
                        tx_byte_r[`GPIB_RQS_BIT] <= rsv_r;
                        tx_eoi_r  <= 1'b0;
                        tx_poll_r <= 1'b1;
                        sh_r      <= SH_WAIT;
                    end else if (tx_valid_i && tx_ready_o) begin
                        tx_byte_r <= tx_data_i;                    // R5
                        tx_eoi_r  <= tx_eoi_i;
                        tx_poll_r <= 1'b0;
                        sh_r      <= SH_WAIT;
                    end
                end
                SH_WAIT:  if (!nrfd_i) sh_r <= SH_DRIVE;           // R19
                SH_DRIVE: sh_r <= SH_HOLD;
                SH_HOLD: begin
                    if (!ndac_i) begin
                        sh_r <= SH_IDLE;                           // R19
                    end
                end
                default:  sh_r <= SH_IDLE;
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////
    // Pin drive, all registered; attention and clear are inputs only
    always_ff @(posedge sys_clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            dio_o      <= 8'h00;
            dio_oe_o   <= 8'h00;
            dav_o      <= 1'b0;
            dav_oe_o   <= 1'b0;
            nrfd_o     <= 1'b0;
            nrfd_oe_o  <= 1'b0;
            ndac_o     <= 1'b0;
            ndac_oe_o  <= 1'b0;
            eoi_o      <= 1'b0;
            eoi_oe_o   <= 1'b0;
            srq_o      <= 1'b0;
            srq_oe_o   <= 1'b0;
            tx_ready_o <= 1'b0;
        end else begin
            // Data lines never answer an identify sequence
            dio_o     <= tx_byte_r;                                // R15
            dio_oe_o  <= {8{tacs_r && !ctl_i.atn &&
                            (sh_r == SH_DRIVE || sh_r == SH_HOLD)}}; // R7
            // Valid goes away together with the data lines, never after
            dav_o     <= sh_r == SH_HOLD && tacs_r && !ctl_i.atn;
            dav_oe_o  <= sh_r == SH_HOLD && tacs_r && !ctl_i.atn;  // R19
            eoi_o     <= tx_eoi_r && sh_r == SH_HOLD;
            eoi_oe_o  <= tx_eoi_r && sh_r == SH_HOLD && !ctl_i.atn;
            nrfd_o    <= ah_r != AH_READY || (lacs_r && rx_hold);
            nrfd_oe_o <= ah_r != AH_READY || (lacs_r && rx_hold);  // R6
            ndac_o    <= ah_on && ah_r != AH_DONE;
            ndac_oe_o <= ah_on && ah_r != AH_DONE;
            srq_o     <= rsv_r;                                    // R11
            srq_oe_o  <= rsv_r;
            tx_ready_o <= sh_r == SH_IDLE && tacs_r && !spe_r &&
                          !(tx_valid_i && tx_ready_o) &&
                          !ctl_i.atn && !ctl_i.ifc;                // R16
        end
    end

    assign listen_o = lacs_r;
    assign talk_o   = tacs_r;
    assign remote_o = rem_r;
    assign spoll_o  = spe_r;
    assign rx_valid_o = rx_valid_r;

endmodule

// *** tb/gpib_dev_assertions.sv ***
module gpib_dev_assertions
    import gpib_dev_pkg::*;
(
    input wire logic       sys_clk_i,
    input wire logic       rst_b_i,
    input wire logic       talk_only_i,
    input wire bus_ctl_s   ctl_i,
    input wire logic [7:0] dio_i,
    input wire logic       dav_i,
    input wire logic       nrfd_i,
    input wire logic       ndac_i,
    input wire logic [7:0] dio_o,
    input wire logic [7:0] dio_oe_o,
    input wire logic       dav_o,
    input wire logic       dav_oe_o,
    input wire logic       ndac_oe_o,
    input wire rx_byte_s   rx_o,
    input wire logic       listen_o,
    input wire logic       talk_o,
    input wire logic       dev_clear_o,
    input wire logic       trigger_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic dav_on;
    assign dav_on = dav_o & dav_oe_o;
    ////////////////////////////////////////
    a_dio_talker: assert property (dio_oe_o != 8'h00 |-> talk_o || talk_only_i)
        else $error("data driven while not talker");
    a_dav_nrfd: assert property ($rose(dav_on) |-> !$past(nrfd_i))
        else $error("data valid while listener not ready");
    a_byte_held: assert property (dav_on |-> dio_oe_o == 8'hff && $stable(dio_o))
        else $error("byte not held under data valid");
    a_dav_waits: assert property (dav_on && ndac_i && !ctl_i.ifc
        && !ctl_i.atn |=> dav_on)
        else $error("data valid dropped before acceptance");
    a_ack_latch: assert property ($fell(ndac_oe_o) && $past(dav_i)
        && listen_o && !ctl_i.atn |-> rx_o.data == $past(dio_i))
        else $error("byte released without latch");
    a_ifc_idle: assert property (ctl_i.ifc [*3] |-> !listen_o && !talk_o)
        else $error("addressing kept under interface clear");
    a_role_excl: assert property (!(listen_o && talk_o))
        else $error("listener and talker at once");
    a_trig_listen: assert property (trigger_o |-> listen_o)
        else $error("trigger while not listener");
    a_clr_pulse: assert property (dev_clear_o |=> !dev_clear_o)
        else $error("clear pulse too long");
    a_no_ident: assert property ((ctl_i.atn && ctl_i.eoi) [*3]
        |-> dio_oe_o == 8'h00)
        else $error("data driven during identify");
endmodule

// *** tb/gpib_ctrl_model.sv ***
module gpib_ctrl_model
    import gpib_dev_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] dio_o,
    input  wire logic [7:0] dio_oe_o,
    input  wire logic       dav_o,
    input  wire logic       dav_oe_o,
    input  wire logic       nrfd_o,
    input  wire logic       nrfd_oe_o,
    input  wire logic       ndac_o,
    input  wire logic       ndac_oe_o,
    output logic [7:0]      bus_dio_o,
    output bus_ctl_s        bus_ctl_o,
    output logic            bus_dav_o,
    output logic            bus_nrfd_o,
    output logic            bus_ndac_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] dio_c = 8'h00;
    bus_ctl_s   ctl_c = '0;
    logic       dav_c = 1'b0;
    logic       nrfd_c = 1'b0;
    logic       ndac_c = 1'b0;
    // Open collector: a released line reads false
    assign bus_dio_o = dio_c | (dio_o & dio_oe_o);
    assign bus_dav_o = dav_c | (dav_o & dav_oe_o);
    assign bus_nrfd_o = nrfd_c | (nrfd_o & nrfd_oe_o);
    assign bus_ndac_o = ndac_c | (ndac_o & ndac_oe_o);
    assign bus_ctl_o = ctl_c;
    ////////////////////////////////////////
    task automatic send(input logic [7:0] b, input logic atn);
        int n;
        ctl_c.atn = atn;
        for (n = 0; n < 40 && bus_nrfd_o !== 1'b0; n++) @(posedge sys_clk_i) #1;
        dio_c = b;
        @(posedge sys_clk_i) #1;
        dav_c = 1'b1;
        @(posedge sys_clk_i) #1;
        for (n = 0; n < 40 && bus_ndac_o !== 1'b0; n++) @(posedge sys_clk_i) #1;
        dav_c = 1'b0;
        // Stale data would hide a missed latch
        dio_c = ~b;
        repeat (2) @(posedge sys_clk_i) #1;
    endtask
    task automatic recv(output logic [7:0] b);
        int n;
        ndac_c = 1'b1;
        dio_c = 8'h00;
        ctl_c.atn = 1'b0;
        nrfd_c = 1'b0;
        for (n = 0; n < 60 && bus_dav_o !== 1'b1; n++) @(posedge sys_clk_i) #1;
        b = bus_dio_o;
        nrfd_c = 1'b1;
        ndac_c = 1'b0;
        for (n = 0; n < 40 && bus_dav_o !== 1'b0; n++) @(posedge sys_clk_i) #1;
        nrfd_c = 1'b0;
    endtask
endmodule

// *** tb/gpib_dev_tb.sv ***
module gpib_dev_tb;
    import gpib_dev_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MLA = 8'h36;
    localparam logic [7:0] MTA = 8'h56;
    logic sys_clk_i = 1'b0, rst_b_i = 1'b0, talk_only_i = 1'b0;
    logic tx_eoi_i = 1'b0, tx_valid_i = 1'b0, rx_ready_i = 1'b0;
    logic svc_req_i = 1'b0;
    logic [7:0] tx_data_i = 8'h00, status_i = 8'h00, dio_i, dio_o, dio_oe_o;
    bus_ctl_s ctl_i;
    rx_byte_s rx_o;
    logic dav_i, nrfd_i, ndac_i, dav_o, dav_oe_o, nrfd_o, nrfd_oe_o;
    logic ndac_o, ndac_oe_o, eoi_o, eoi_oe_o, srq_o, srq_oe_o, tx_ready_o;
    logic rx_valid_o, listen_o, talk_o, remote_o, spoll_o;
    logic dev_clear_o, trigger_o;
    logic [7:0] st;
    int mismatches = 0, n_compared = 0, clears = 0, trigs = 0, eois = 0;
    assign st = {4'h0, listen_o, talk_o, remote_o, spoll_o};
    always #2.5 sys_clk_i = ~sys_clk_i;
    gpib_dev u_dut (.my_addr_i(5'h16), .*);
    gpib_ctrl_model u_ctl (.bus_dio_o(dio_i), .bus_ctl_o(ctl_i),
        .bus_dav_o(dav_i), .bus_nrfd_o(nrfd_i), .bus_ndac_o(ndac_i), .*);
    // Clear and trigger pulses are one cycle, so count them (and end-or-identify cycles) rather than sample
    always @(posedge sys_clk_i) begin
        if (dev_clear_o === 1'b1) clears <= clears + 1;
        if (trigger_o === 1'b1) trigs <= trigs + 1;
        if (eoi_o === 1'b1 && eoi_oe_o === 1'b1) eois <= eois + 1;
    end
    ////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic take;
        rx_ready_i = 1'b1;
        @(posedge sys_clk_i) #1;
        rx_ready_i = 1'b0;
    endtask
    ////////////////////////////////////////
    task automatic t_addr;
        u_ctl.send(8'h04, 1'b1);
        check(8'(clears), 8'd0);
        u_ctl.send(8'h76, 1'b1);
        check(st, 8'h00);
        u_ctl.send(8'h3f, 1'b1);
        u_ctl.send(MLA, 1'b1);
        check(st, 8'h08);
        u_ctl.send(8'h04, 1'b1);
        check(8'(clears), 8'd1);
        u_ctl.send(8'h08, 1'b1);
        check(8'(trigs), 8'd1);
        u_ctl.send(8'h3f, 1'b1);
        u_ctl.send(8'h08, 1'b1);
        check(8'(trigs), 8'd1);
        u_ctl.send(8'h14, 1'b1);
        check(8'(clears), 8'd2);
    endtask
    task automatic t_data;
        u_ctl.send(MLA, 1'b1);
        u_ctl.send(8'h2a, 1'b0);
        check(rx_o.data, 8'h2a);
        check({7'h0, rx_valid_o}, 8'h01);
        take;
        check({7'h0, rx_valid_o}, 8'h00);
        u_ctl.ctl_c.eoi = 1'b1;
        u_ctl.send(8'h04, 1'b0);
        u_ctl.ctl_c.eoi = 1'b0;
        check(rx_o.data, 8'h04);
        check({7'h0, rx_o.eoi}, 8'h01);
        check(8'(clears), 8'd2);
        take;
        u_ctl.send(8'h3f, 1'b1);
        u_ctl.send(8'h53, 1'b0);
        check(rx_o.data, 8'h04);
    endtask
    task automatic t_talk;
        logic [7:0] b;
        int n;
        u_ctl.send(MTA, 1'b1);
        check(st, 8'h04);
        u_ctl.nrfd_c = 1'b1;
        u_ctl.ndac_c = 1'b1;
        u_ctl.ctl_c.atn = 1'b0;
        tx_data_i = 8'ha5;
        tx_eoi_i = 1'b1;
        tx_valid_i = 1'b1;
        for (n = 0; n < 20 && tx_ready_o !== 1'b1; n++) @(posedge sys_clk_i) #1;
        @(posedge sys_clk_i) #1;
        tx_valid_i = 1'b0;
        tx_eoi_i = 1'b0;
        repeat (4) @(posedge sys_clk_i) #1;
        u_ctl.recv(b);
        check(b, 8'ha5);
        check(8'(eois != 0), 8'h01);
        u_ctl.ctl_c = '{atn: 1'b1, ifc: 1'b0, ren: 1'b0, eoi: 1'b1};
        repeat (4) @(posedge sys_clk_i) #1;
        check(dio_oe_o, 8'h00);
        u_ctl.ctl_c.eoi = 1'b0;
        u_ctl.send(MLA, 1'b1);
        check(st, 8'h08);
    endtask
    task automatic t_poll;
        logic [7:0] b;
        status_i = 8'h81;
        svc_req_i = 1'b1;
        repeat (3) @(posedge sys_clk_i) #1;
        svc_req_i = 1'b0;
        check({7'h0, srq_o & srq_oe_o}, 8'h01);
        u_ctl.send(8'h3f, 1'b1);
        u_ctl.send(8'h18, 1'b1);
        u_ctl.send(MTA, 1'b1);
        check(st, 8'h05);
        u_ctl.recv(b);
        check(b, 8'hc1);
        check({7'h0, srq_o & srq_oe_o}, 8'h00);
        u_ctl.send(8'h19, 1'b1);
        check(st, 8'h04);
    endtask
    task automatic t_remote;
        u_ctl.ctl_c.ren = 1'b1;
        u_ctl.send(MLA, 1'b1);
        check(st, 8'h0a);
        u_ctl.send(8'h01, 1'b1);
        check(st, 8'h08);
        talk_only_i = 1'b1;
        repeat (3) @(posedge sys_clk_i) #1;
        check(st, 8'h04);
        talk_only_i = 1'b0;
        u_ctl.ctl_c.ifc = 1'b1;
        repeat (4) @(posedge sys_clk_i) #1;
        check(st & 8'h0c, 8'h00);
        u_ctl.ctl_c = '0;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge sys_clk_i);
        #1 rst_b_i = 1'b1;
        repeat (4) @(posedge sys_clk_i) #1;
        check(st, 8'h00);
        t_addr;
        t_data;
        t_talk;
        t_poll;
        t_remote;
        report_and_stop;
    end
    initial begin
        #200us;
        mismatches++;
        report_and_stop;
    end
endmodule

bind gpib_dev gpib_dev_assertions u_chk (.*);
